// ---- sim/sori_far.sv ----
`timescale 1ns/1ps
// ****************************************
// sensors, restart button and the contactor of output a
// ****************************************
module sori_far (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_occupy,
  input  wire logic       i_press,
  input  wire logic [7:0] i_press_len,
  input  wire logic       i_fb_stuck,
  input  wire logic       i_out_a,
  output logic [1:0]      o_field_free,
  output logic            o_restart,
  output logic            o_feedback
);
  logic [7:0] left_ff = 8'h00;
  // button held for the commanded number of cycles
  always_ff @(posedge i_clk)
  begin
    if (i_press)
      left_ff <= i_press_len;
    else if (left_ff != 8'h00)
      left_ff <= left_ff - 8'h01;
  end
  assign o_restart    = left_ff != 8'h00;
  assign o_field_free = ~i_occupy;
  // contactor of output a: closed while dropped out, welded stays closed
  assign o_feedback = i_fb_stuck | ~i_out_a;
endmodule : sori_far

// ---- sim/sori_top_sva.sv ----
`timescale 1ns/1ps
// ****************************************
// interlock port checker
// ****************************************
module sori_top_chk
  import sori_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_hsel,
  input wire logic [7:0]  i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [1:0]  i_field_free,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_safety_output_a,
  input wire logic        o_safety_output_b,
  input wire logic [1:0]  o_red,
  input wire logic [1:0]  o_green,
  input wire logic [1:0]  o_yellow,
  input wire logic        o_ready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // read of the first unmapped word
  sequence s_rd_hole;
    i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr == 8'h1c;
  endsequence
  // an output live while some field is occupied
  sequence s_trip;
    (o_safety_output_a || o_safety_output_b) && i_field_free != 2'b11;
  endsequence
  a_reset_safe: assert property ($fell(i_sys_rst) |->
    !o_safety_output_a && !o_safety_output_b && o_red == 2'b11)
    else $error("output live after reset");
  a_trip_off: assert property (s_trip |-> ##[1:2]
    !o_safety_output_a && !o_safety_output_b)
    else $error("output stays on with field occupied");
  a_lamp_a: assert property (o_safety_output_a |->
    o_green[0] && !o_red[0] && !o_yellow[0])
    else $error("lamps wrong while output a on");
  a_lamp_b: assert property (o_safety_output_b |->
    o_green[1] && !o_red[1] && !o_yellow[1])
    else $error("lamps wrong while output b on");
  a_off_red: assert property ($fell(o_safety_output_a) |-> o_red[0])
    else $error("red lamp dark on output off");
  a_ready_first: assert property ($rose(o_ready) |-> ##[0:1]
    (o_safety_output_a || o_safety_output_b))
    else $error("ready without an enabled output");
  a_enable_free: assert property (
    $rose(o_safety_output_a) || $rose(o_safety_output_b)
    |-> $past(i_field_free) == 2'b11)
    else $error("output enabled on occupied field");
  a_hole_zero: assert property (s_rd_hole |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : sori_top_chk

bind sori_top sori_top_chk i_sori_top_chk (.i_clk, .i_sys_rst, .i_hsel,
  .i_haddr, .i_htrans, .i_hwrite, .i_hready, .i_field_free, .o_hrdata,
  .o_safety_output_a, .o_safety_output_b, .o_red, .o_green, .o_yellow,
  .o_ready);

// ---- sim/test_sori_top.sv ----
`timescale 1ns/1ps
module test_sori_top;
  import sori_pkg::*;
  logic i_clk, i_sys_rst, i_hsel, i_hwrite, i_hready, press, fb_stuck;
  logic [7:0] i_haddr, press_len;
  logic [1:0] i_htrans, i_field_free, i_case_sensors, occupy;
  logic [1:0] o_red, o_green, o_yellow;
  logic [2:0] i_hsize;
  logic [31:0] i_hwdata, o_hrdata;
  logic o_hreadyout, o_hresp, i_restart_input, i_contactor_feedback;
  logic o_safety_output_a, o_safety_output_b, o_ready, o_irq;
  int num_errors, n_compared, cyc, n;
  // ****************************************
  // design and far side
  // ****************************************
  sori_top #(.SEC_DIV(10), .RES_MIN(4), .RES_MAX(40), .FLASH_DIV(4))
  i_sori_top (.i_clk, .i_sys_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
    .i_field_free, .i_case_sensors, .i_restart_input,
    .i_contactor_feedback, .o_safety_output_a, .o_safety_output_b, .o_red,
    .o_green, .o_yellow, .o_ready, .o_irq);
  sori_far i_sori_far (.i_clk, .i_occupy(occupy), .i_press(press),
    .i_press_len(press_len), .i_fb_stuck(fb_stuck),
    .i_out_a(o_safety_output_a),
    .o_field_free(i_field_free), .o_restart(i_restart_input),
    .o_feedback(i_contactor_feedback));
  // the only slave's hreadyout is the bus's hready
  assign i_hready = o_hreadyout;
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // hang guard, far above the longest scenario
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      summarize();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input string what, input logic [31:0] seen, exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge i_clk);
    i_hsel <= 1'b1; i_htrans <= 2'h2; i_haddr <= a; i_hwrite <= wr;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0; i_htrans <= 2'h0; i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    q = o_hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, q, exp);
    chk("hresp", o_hresp, 1'b0);
  endtask : rd
  task step(input int k);
    repeat (k) @(negedge i_clk);
  endtask : step
  // occupy fields s for k cycles, then clear them
  task intrude(input logic [1:0] s, input int k);
    @(posedge i_clk);
    occupy <= s;
    repeat (k) @(posedge i_clk);
    occupy <= 2'b00;
  endtask : intrude
  task wait_on();
    n = 0;
    step(1);
    while (o_safety_output_a !== 1'b1 && o_safety_output_b !== 1'b1
           && n < 300)
    begin
      step(1);
      n = n + 1;
    end
  endtask : wait_on
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset();
    chk("outs", {o_safety_output_a, o_safety_output_b}, 2'b00);
    chk("red", o_red, 2'b11);
    chk("ready", o_ready, 1'b0);
    rd(ADDR_CTRL, 32'h19, "ctrl");
    rd(ADDR_DELAY, 32'h1, "delay");
    rd(ADDR_RESP, 32'h1, "resp");
    rd(ADDR_STAT, 32'h61, "stat");
    rd(8'h1c, 32'h0, "hole");
    rd(ADDR_IRQCLR, 32'h0, "irqclr");
  endtask : t_reset
  task t_startup();
    wr(ADDR_RESP, 32'h6);
    wr(ADDR_IRQEN, 32'h1);
    intrude(2'b01, 3);
    step(30);
    chk("one sensor", o_safety_output_a, 1'b0);
    intrude(2'b10, 3);
    wait_on();
    chk("resp time", n >= 5 && n <= 10, 1'b1);
    step(1);
    chk("both", {o_safety_output_a, o_safety_output_b}, 2'b11);
    chk("lamps", {o_green, o_red}, 4'hc);
    chk("ready", {o_ready, o_irq}, 2'b11);
    wr(ADDR_IRQCLR, 32'hf);
    step(1);
    chk("irq clr", o_irq, 1'b0);
  endtask : t_startup
  task t_delay();
    wr(ADDR_IRQEN, 32'h2);
    wr(ADDR_CTRL, 32'h0b);
    wr(ADDR_DELAY, 32'h2);
    intrude(2'b11, 4);
    step(1);
    chk("trip", {o_safety_output_a, o_safety_output_b, o_irq}, 3'h1);
    wr(ADDR_IRQCLR, 32'hf);
    step(12);
    intrude(2'b01, 2);
    wait_on();
    chk("delay", n >= 15 && n <= 34, 1'b1);
    step(1);
    chk("a only", {o_safety_output_a, o_safety_output_b}, 2'b10);
  endtask : t_delay
  task t_button();
    logic hi, lo;
    wr(ADDR_CTRL, 32'h15);
    intrude(2'b11, 3);
    step(20);
    hi = 1'b0;
    lo = 1'b0;
    repeat (12)
    begin
      step(1);
      hi = hi | o_yellow[1];
      lo = lo | !o_yellow[1];
    end
    chk("flash", {hi, lo, o_safety_output_b}, 3'h6);
    @(posedge i_clk);
    press_len <= 8'h2;
    press <= 1'b1;
    @(posedge i_clk);
    press <= 1'b0;
    step(6);
    chk("short", o_safety_output_b, 1'b0);
    rd(ADDR_IRQST, 32'h6, "res fault");
    @(posedge i_clk);
    press_len <= 8'ha;
    press <= 1'b1;
    @(posedge i_clk);
    press <= 1'b0;
    wait_on();
    step(1);
    chk("b only", {o_safety_output_a, o_safety_output_b}, 2'b01);
  endtask : t_button
  task t_feedback();
    wr(ADDR_IRQCLR, 32'hf);
    @(posedge i_clk);
    fb_stuck <= 1'b1;
    step(3);
    rd(ADDR_IRQST, 32'h0, "fb b only");
    wr(ADDR_CTRL, 32'h19);
    step(3);
    rd(ADDR_IRQST, 32'h8, "fb fault");
    @(posedge i_clk);
    fb_stuck <= 1'b0;
  endtask : t_feedback
  // second reset: one tested sensor, then startup test switched off
  task t_notest();
    @(posedge i_clk);
    i_sys_rst      <= 1'b1;
    i_case_sensors <= 2'b01;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    step(2);
    chk("rst outs", {o_safety_output_a, o_safety_output_b, o_ready, o_red},
        5'h03);
    rd(ADDR_STAT, 32'h21, "one case");
    wr(ADDR_CTRL, 32'h18);
    wait_on();
    chk("no test", {o_safety_output_a, o_safety_output_b, o_ready},
        3'h7);
  endtask : t_notest
  task summarize();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  initial
  begin
    num_errors = 0; n_compared = 0; cyc = 0;
    i_sys_rst = 1'b1; i_hsel = 1'b0; i_hwrite = 1'b0;
    i_haddr = 8'h0; i_htrans = 2'h0; i_hsize = 3'h2; i_hwdata = 32'h0;
    i_case_sensors = 2'b11; occupy = 2'b00; press = 1'b0;
    press_len = 8'h0; fb_stuck = 1'b0;
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    step(2);
    t_reset();
    t_startup();
    t_delay();
    t_button();
    t_feedback();
    t_notest();
    summarize();
  end
endmodule : test_sori_top

// ---- verilog/sori_pkg.sv ----
package sori_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned SEC_CYCLES      = CLK_HZ;
  // restart button: valid press longer than 200 ms, shorter than 5 s
  localparam int unsigned RES_MIN_MS      = 200;
  localparam int unsigned RES_MAX_MS      = 5000;
  localparam int unsigned RES_MIN_CYCLES  =
    (RES_MIN_MS * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS * 1000;
  localparam int unsigned RES_MAX_CYCLES  =
    RES_MAX_MS * 1000 / CLK_PERIOD_NS * 1000;
  // yellow lamp flash half period
  localparam int unsigned FLASH_MS        = 250;
  localparam int unsigned FLASH_CYCLES    =
    FLASH_MS * 1000 / CLK_PERIOD_NS * 1000;
  localparam int unsigned CNT_W           = 32;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DELAY  = 8'h04;
  localparam logic [7:0] ADDR_RESP   = 8'h08;
  localparam logic [7:0] ADDR_STAT   = 8'h0c;
  localparam logic [7:0] ADDR_IRQST  = 8'h10;
  localparam logic [7:0] ADDR_IRQCLR = 8'h14;
  localparam logic [7:0] ADDR_IRQEN  = 8'h18;

  // control fields
  localparam int unsigned CTRL_TEST_BIT  = 0;
  localparam int unsigned CTRL_MODE_LSB  = 1;
  localparam int unsigned CTRL_OUTS_LSB  = 3;
  localparam int unsigned CTRL_W         = 5;
  localparam logic [4:0]  CTRL_RST       = 5'h19;

  // restart modes
  localparam logic [1:0] MODE_IMMED  = 2'h0;
  localparam logic [1:0] MODE_DELAY  = 2'h1;
  localparam logic [1:0] MODE_BUTTON = 2'h2;
  // output selection
  localparam logic [1:0] OUTS_A      = 2'h1;
  localparam logic [1:0] OUTS_B      = 2'h2;
  localparam logic [1:0] OUTS_BOTH   = 2'h3;

  localparam logic [7:0]  DELAY_RST  = 8'h01;
  localparam logic [15:0] RESP_RST   = 16'h0001;

  // interrupt events
  localparam int unsigned EV_READY   = 0;
  localparam int unsigned EV_TRIP    = 1;
  localparam int unsigned EV_RESFLT  = 2;
  localparam int unsigned EV_FBFLT   = 3;
  localparam int unsigned EV_W       = 4;

  // ****************************************************************
  // interlock states
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_TEST  = 5'b00001,
    ST_WAIT  = 5'b00010,
    ST_HOLD  = 5'b00100,
    ST_BTN   = 5'b01000,
    ST_ON    = 5'b10000
  } sori_state_type;

endpackage : sori_pkg

// ---- verilog/sori_tick.sv ----
`timescale 1ns/1ps
// divider: one pulse per period, restarts while held in reset
module sori_tick
  import sori_pkg::*;
#(
  parameter int unsigned PERIOD = SEC_CYCLES
)(
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  output logic      o_tick
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } sori_tick_type;

  sori_tick_type st_ff;
  sori_tick_type nxt_st;

  // ****************************************************************
  // divider
  // ****************************************************************
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt >= CNT_W'(PERIOD - 1))
    begin
      nxt_st.cnt  = '0;
      nxt_st.tick = 1'b1;
    end
    else
    begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_tick = st_ff.tick;

endmodule : sori_tick

// ---- verilog/sori_top.sv ----
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module sori_top
  import sori_pkg::*;
#(
  parameter int unsigned SEC_DIV   = SEC_CYCLES,
  parameter int unsigned RES_MIN   = RES_MIN_CYCLES,
  parameter int unsigned RES_MAX   = RES_MAX_CYCLES,
  parameter int unsigned FLASH_DIV = FLASH_CYCLES
)(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // sensors: field free, one bit per sensor
  input  wire logic [1:0]  i_field_free,
  // sensors used by the first monitoring case(s)
  input  wire logic [1:0]  i_case_sensors,
  input  wire logic        i_restart_input,
  input  wire logic        i_contactor_feedback,
  output logic             o_safety_output_a,
  output logic             o_safety_output_b,
  output logic [1:0]       o_red,
  output logic [1:0]       o_green,
  output logic [1:0]       o_yellow,
  output logic             o_ready,
  output logic             o_irq
);

  typedef struct packed {
    sori_state_type      state;
    logic [CTRL_W-1:0]   ctrl;
    logic [7:0]          delay;
    logic [15:0]         resp;
    logic [1:0]          act;      // sensors under test
    logic [1:0]          seen;     // intrusion seen per sensor
    logic                ready;
    logic [15:0]         wait_cnt;
    logic [CNT_W-1:0]    res_cnt;
    logic                res_prev;
    logic                res_ok;
    logic [CNT_W-1:0]    fl_cnt;
    logic                fl;
    logic [EV_W-1:0]     irq_st;
    logic [EV_W-1:0]     irq_en;
    logic                dph;      // data phase pending
    logic                dwr;
    logic [7:0]          daddr;
    logic [31:0]         rdata;
    logic                armed;    // tested sensors latched
  } sori_top_type;

  sori_top_type st_ff;
  sori_top_type nxt_st;
  logic         sec_tick;
  logic         sec_clr;

  // restarted outside an unbroken free hold, so a whole second
  // always passes before the first delay step
  sori_tick #(
    .PERIOD (SEC_DIV)
  ) u_sec (
    .i_clk     (i_clk),
    .i_sys_rst (sec_clr),
    .o_tick    (sec_tick)
  );

  // ****************************************************************
  // combinational next state
  // ****************************************************************
  logic       all_free;
  logic       outs_on;
  logic [1:0] mode;
  logic [1:0] outs;
  logic [EV_W-1:0] ev;
  logic       addr_ph;

  always_comb
  begin
    nxt_st   = st_ff;
    mode     = st_ff.ctrl[CTRL_MODE_LSB +: 2];
    outs     = st_ff.ctrl[CTRL_OUTS_LSB +: 2];
    all_free = &(i_field_free | ~st_ff.act);
    outs_on  = (st_ff.state == ST_ON);
    ev       = '0;

    // restart input: pulse length checked on release
    nxt_st.res_prev = i_restart_input;
    nxt_st.res_ok   = 1'b0;
    if (i_restart_input)
    begin
      if (st_ff.res_cnt != '1)
        nxt_st.res_cnt = st_ff.res_cnt + 1'b1;
    end
    else
    begin
      nxt_st.res_cnt = '0;
    end
    if (st_ff.res_prev && !i_restart_input)
    begin
      if (st_ff.res_cnt > CNT_W'(RES_MIN) &&
          st_ff.res_cnt < CNT_W'(RES_MAX))
        nxt_st.res_ok = 1'b1;
      else
        ev[EV_RESFLT] = 1'b1;
    end
    // held beyond the longest valid press
    if (i_restart_input && st_ff.res_cnt == CNT_W'(RES_MAX))
      ev[EV_RESFLT] = 1'b1;
    // feedback belongs to output a only; b alone must not fault
    if (outs_on && outs[0] && i_contactor_feedback)
      ev[EV_FBFLT] = 1'b1;

    // yellow flash divider
    if (st_ff.fl_cnt >= CNT_W'(FLASH_DIV - 1))
    begin
      nxt_st.fl_cnt = '0;
      nxt_st.fl     = ~st_ff.fl;
    end
    else
    begin
      nxt_st.fl_cnt = st_ff.fl_cnt + 1'b1;
    end

    // interlock sequence
    unique case (st_ff.state)
      ST_TEST:
      begin
        // each tested sensor: intrusion, then free again
        nxt_st.seen = st_ff.seen | (st_ff.act & ~i_field_free);
        if (&(st_ff.seen | ~st_ff.act) && all_free)
        begin
          nxt_st.state    = ST_WAIT;
          nxt_st.wait_cnt = st_ff.resp;
        end
      end
      ST_WAIT:
      begin
        // response time in clock cycles before enabling
        if (!all_free)
          nxt_st.wait_cnt = st_ff.resp;
        else if (st_ff.wait_cnt > 16'h0001)
          nxt_st.wait_cnt = st_ff.wait_cnt - 1'b1;
        else if (mode == MODE_DELAY)
        begin
          nxt_st.state    = ST_HOLD;
          nxt_st.wait_cnt = {8'h00, st_ff.delay};
        end
        else if (mode == MODE_BUTTON)
          nxt_st.state = ST_BTN;
        else
          nxt_st.state = ST_ON;
      end
      ST_HOLD:
      begin
        if (!all_free)
          nxt_st.wait_cnt = {8'h00, st_ff.delay};
        else if (st_ff.wait_cnt == 16'h0000)
          nxt_st.state = ST_ON;
        else if (sec_tick)
          nxt_st.wait_cnt = st_ff.wait_cnt - 1'b1;
      end
      ST_BTN:
      begin
        if (!all_free)
          nxt_st.state = ST_WAIT;
        else if (st_ff.res_ok)
          nxt_st.state = ST_ON;
      end
      ST_ON:
      begin
        if (!all_free)
        begin
          nxt_st.state    = ST_WAIT;
          nxt_st.wait_cnt = st_ff.resp;
          ev[EV_TRIP]     = 1'b1;
        end
      end
      default:
      begin
        nxt_st.state = ST_TEST;
      end
    endcase

    // tested sensors come from the first active case, latched once
    if (!st_ff.armed)
    begin
      nxt_st.armed = 1'b1;
      nxt_st.act   = (i_case_sensors == 2'b00) ? 2'b01
                                                : i_case_sensors;
    end
    // test disabled: skip straight to the restart stage
    if (st_ff.state == ST_TEST && !st_ff.ctrl[CTRL_TEST_BIT])
    begin
      nxt_st.state    = ST_WAIT;
      nxt_st.wait_cnt = st_ff.resp;
    end

    if (st_ff.state != ST_ON && nxt_st.state == ST_ON && !st_ff.ready)
    begin
      nxt_st.ready = 1'b1;
      ev[EV_READY] = 1'b1;
    end

    // ahb-lite: address phase capture, data phase in next cycle
    addr_ph = i_hsel && i_hready && i_htrans[1];
    nxt_st.dph = addr_ph;
    if (addr_ph)
    begin
      nxt_st.dwr   = i_hwrite;
      nxt_st.daddr = i_haddr;
      unique case (i_haddr)
        ADDR_CTRL:   nxt_st.rdata = {27'h0, st_ff.ctrl};
        ADDR_DELAY:  nxt_st.rdata = {24'h0, st_ff.delay};
        ADDR_RESP:   nxt_st.rdata = {16'h0, st_ff.resp};
        ADDR_STAT:   nxt_st.rdata = {22'h0, st_ff.ready, st_ff.seen,
                                     st_ff.act, st_ff.state};
        ADDR_IRQST:  nxt_st.rdata = {28'h0, st_ff.irq_st};
        ADDR_IRQEN:  nxt_st.rdata = {28'h0, st_ff.irq_en};
        default:     nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    // interrupt status: set wins over clear
    if (st_ff.dph && st_ff.dwr && st_ff.daddr == ADDR_IRQCLR)
      nxt_st.irq_st = st_ff.irq_st & ~i_hwdata[EV_W-1:0];
    nxt_st.irq_st = nxt_st.irq_st | ev;

    if (st_ff.dph && st_ff.dwr)
    begin
      unique case (st_ff.daddr)
        ADDR_CTRL:  nxt_st.ctrl   = i_hwdata[CTRL_W-1:0];
        ADDR_DELAY: nxt_st.delay  = i_hwdata[7:0];
        ADDR_RESP:  nxt_st.resp   = i_hwdata[15:0];
        ADDR_IRQEN: nxt_st.irq_en = i_hwdata[EV_W-1:0];
        default:    nxt_st.irq_en = st_ff.irq_en;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      st_ff          <= '0;
      st_ff.state    <= ST_TEST;
      st_ff.ctrl     <= CTRL_RST;
      st_ff.delay    <= DELAY_RST;
      st_ff.resp     <= RESP_RST;
      st_ff.act      <= 2'b01;
      st_ff.res_prev <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // an output only goes live when selected and interlock is on
  assign o_safety_output_a = (st_ff.state == ST_ON) && outs[0];
  assign o_safety_output_b = (st_ff.state == ST_ON) && outs[1];
  assign o_green  = {o_safety_output_b, o_safety_output_a};
  assign o_red    = ~o_green;
  assign o_yellow = (st_ff.state == ST_BTN) ?
                    (outs & {2{st_ff.fl}}) : 2'b00;
  assign o_ready  = st_ff.ready;
  assign o_irq    = |(st_ff.irq_st & st_ff.irq_en);
  assign o_hrdata    = st_ff.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  // seconds divider runs only while holding with every tested field free
  assign sec_clr = i_sys_rst || (st_ff.state != ST_HOLD) || !all_free;

endmodule : sori_top
